// ===== inc/wwd_pkg.sv
package wwd_pkg;

    // bus geometry: register index times four gives the byte address
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          BYTE_W        = 8;
    localparam logic [7:0]  IDX_CONTROL   = 8'h0C;
    localparam logic [7:0]  IDX_TEST_A    = 8'h0D;
    localparam logic [7:0]  IDX_TEST_B    = 8'h0E;
    localparam logic [7:0]  IDX_SERVICE   = 8'h0F;
    localparam logic [7:0]  IDX_STATUS    = 8'h10;
    localparam logic [7:0]  IDX_CLKCFG    = 8'h11;
    localparam int          IDX_SHIFT     = 2;

    // watchdog_control field positions
    localparam int          CTL_WINDOW    = 7;
    localparam int          CTL_DBGSTOP   = 6;
    localparam int          CTL_MASK      = 5;
    localparam int          CTL_RATE_LSB  = 0;
    localparam int          RATE_W        = 3;
    localparam logic [2:0]  RATE_OFF      = 3'h0;

    // clock configuration field positions
    localparam int          CFG_SECONDARY = 0;
    localparam int          CFG_PRIMARY   = 1;
    localparam int          CFG_PSTOP     = 2;
    localparam int          CFG_PCE       = 3;

    // status field positions
    localparam int          STA_ARMED     = 0;
    localparam int          STA_ENABLED   = 1;
    localparam int          STA_ONCE      = 2;
    localparam int          STA_FORCED    = 3;

    // service byte values
    localparam logic [7:0]  ARM_FIRST     = 8'h55;
    localparam logic [7:0]  ARM_SECOND    = 8'hAA;

    // period exponents, indexed by rate code
    localparam int          CNT_W         = 25;
    localparam int          EXP_W         = 5;
    localparam logic [4:0]  EXP_FORCED    = 5'h18;
    localparam logic [39:0] EXP_SLOW      = {5'h18, 5'h17, 5'h16, 5'h14, 5'h12, 5'h10, 5'h0E, 5'h00};
    localparam logic [39:0] EXP_FAST      = {5'h11, 5'h10, 5'h0F, 5'h0D, 5'h0B, 5'h09, 5'h07, 5'h00};

    typedef struct packed {
        logic       window;
        logic       dbg_stop;
        logic [2:0] rate;
    } wwd_ctrl_s;

    typedef struct packed {
        logic pseudo_stop_clock_enable;
        logic pseudo_stop;
        logic primary;
        logic secondary;
    } wwd_clkcfg_s;

    localparam wwd_ctrl_s   CTRL_RST      = '{window: 1'b0, dbg_stop: 1'b0, rate: 3'h0};
    localparam wwd_clkcfg_s CLKCFG_RST    = '{pseudo_stop_clock_enable: 1'b0, pseudo_stop: 1'b0, primary: 1'b0, secondary: 1'b0};

    typedef enum logic {
        ARM_IDLE = 1'b0,
        ARM_HALF = 1'b1
    } wwd_arm_e;

endpackage : wwd_pkg

// ===== rtl/wwd_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change passes once stages two and three agree
module wwd_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q, s2_q, s3_q, q_d;

    // per bit: take stage three only where it matches stage two
    always_comb begin
        q_d = (q_o & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q)); // hold while the stages disagree
    end

    // stage one feeds stage two and nothing else
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q_o  <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_o  <= q_d;
        end
    end
endmodule : wwd_sync3

// ===== rtl/wwd_tick.sv
`timescale 1ns/1ps
// picks the count source and turns its rising edges into one-cycle enables
module wwd_tick (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic auto_clk_i,
    input  wire logic irc_clk_i,
    input  wire logic osc_clk_i,
    input  wire logic primary_i,
    input  wire logic secondary_i,
    output logic      tick_o
);
    logic src;
    logic prev_q, prev_d;
    logic half_q, half_d;
    logic tick_d;

    // primary select halves the autonomous clock by skipping every other edge
    always_comb begin
        src    = primary_i ? auto_clk_i : (secondary_i ? osc_clk_i : irc_clk_i);
        prev_d = src;
        half_d = half_q;
        tick_d = 1'b0;
        if (src && !prev_q) begin
            half_d = primary_i ? ~half_q : 1'b0;
            tick_d = !primary_i || half_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
            half_q <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            prev_q <= prev_d;
            half_q <= half_d;
            tick_o <= tick_d;
        end
    end
endmodule : wwd_tick

// ===== rtl/wwd_top.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module wwd_top (
    input  wire logic                  REF_CLK_I,
    input  wire logic                  RST_I,
    input  wire logic [7:0]            AVS_ADDRESS_I,
    input  wire logic                  AVS_READ_I,
    input  wire logic                  AVS_WRITE_I,
    input  wire logic [31:0]           AVS_WRITEDATA_I,
    input  wire logic [3:0]            AVS_BYTEENABLE_I,
    output logic      [31:0]           AVS_READDATA_O,
    output logic                       AVS_WAITREQUEST_O,
    input  wire logic                  SPECIAL_MODE_I,
    input  wire logic                  STOP_MODE_I,
    input  wire logic                  DEBUG_ACTIVE_I,
    input  wire logic                  NVM_LOAD_I,
    input  wire wwd_pkg::wwd_ctrl_s    NVM_CTRL_I,
    input  wire logic                  AUTO_CLK_I,
    input  wire logic                  IRC_CLK_I,
    input  wire logic                  OSC_CLK_I,
    input  wire logic                  OSC_VALID_I,
    output logic                       WDOG_RESET_O,
    output logic                       RTI_FREEZE_O
);

    // address decode used by both the read mux and the write strobes
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
        hit = (addr == (idx << wwd_pkg::IDX_SHIFT));
    endfunction : hit

    // period exponent for the rate code and clock branch
    function automatic logic [4:0] rate_exp(input logic [2:0] rate, input logic fast);
        logic [39:0] tbl;
        tbl      = fast ? wwd_pkg::EXP_FAST : wwd_pkg::EXP_SLOW;
        rate_exp = tbl[rate*wwd_pkg::EXP_W +: wwd_pkg::EXP_W];
    endfunction : rate_exp

    localparam logic [24:0] CNT_ONE = 25'h000_0001;

    // ------------------------------------------------------------------
    // pin inputs: count clocks and oscillator status cross in through three flops
    logic        auto_s, irc_s, osc_s, ovalid_s;
    logic        tick;

    wwd_sync3 #(
        .W (4)
    ) u_sync (
        .clk_i (REF_CLK_I),
        .rst_i (RST_I),
        .d_i   ({OSC_VALID_I, OSC_CLK_I, IRC_CLK_I, AUTO_CLK_I}),
        .q_o   ({ovalid_s, osc_s, irc_s, auto_s})
    );

    wwd_pkg::wwd_ctrl_s   ctrl_q, ctrl_d;
    wwd_pkg::wwd_clkcfg_s cfg_q, cfg_d;

    wwd_tick u_tick (
        .clk_i       (REF_CLK_I),
        .rst_i       (RST_I),
        .auto_clk_i  (auto_s),
        .irc_clk_i   (irc_s),
        .osc_clk_i   (osc_s),
        .primary_i   (cfg_q.primary),
        .secondary_i (cfg_q.secondary),
        .tick_o      (tick)
    );

    // ------------------------------------------------------------------
    // bus slave: waitrequest drops for exactly one cycle, one cycle after the request
    logic        wait_q, wait_d;
    logic [31:0] rdata_d;
    logic        req, fire_acc, wr_fire;
    logic [7:0]  wd;
    logic        wr_ctl, wr_cfg, wr_svc_raw, wr_test_a, wr_test_b;
    logic [7:0]  test_a_q, test_a_d, test_b_q, test_b_d;
    logic        once_q, once_d;
    logic        ovalid_prev_q;
    wwd_pkg::wwd_arm_e arm_q, arm_d;
    logic [24:0] cnt_q, cnt_d;
    logic        enabled, forced;

    always_comb begin
        req        = AVS_READ_I || AVS_WRITE_I;
        fire_acc   = req && !wait_q;
        wait_d     = !(req && wait_q);
        wr_fire    = fire_acc && AVS_WRITE_I && AVS_BYTEENABLE_I[0];
        wd         = AVS_WRITEDATA_I[7:0];
        wr_ctl     = wr_fire && hit(AVS_ADDRESS_I, wwd_pkg::IDX_CONTROL);
        wr_cfg     = wr_fire && hit(AVS_ADDRESS_I, wwd_pkg::IDX_CLKCFG);
        wr_svc_raw = wr_fire && hit(AVS_ADDRESS_I, wwd_pkg::IDX_SERVICE);
        wr_test_a  = wr_fire && SPECIAL_MODE_I && hit(AVS_ADDRESS_I, wwd_pkg::IDX_TEST_A);
        wr_test_b  = wr_fire && SPECIAL_MODE_I && hit(AVS_ADDRESS_I, wwd_pkg::IDX_TEST_B);
    end

    // read mux; mask bit and the service register always read back zero
    always_comb begin
        rdata_d = '0;
        if (hit(AVS_ADDRESS_I, wwd_pkg::IDX_CONTROL)) begin
            rdata_d[wwd_pkg::CTL_WINDOW]  = ctrl_q.window;
            rdata_d[wwd_pkg::CTL_DBGSTOP] = ctrl_q.dbg_stop;
            rdata_d[wwd_pkg::CTL_RATE_LSB +: wwd_pkg::RATE_W] = ctrl_q.rate;
        end else if (hit(AVS_ADDRESS_I, wwd_pkg::IDX_TEST_A)) begin
            rdata_d[wwd_pkg::BYTE_W-1:0] = test_a_q;
        end else if (hit(AVS_ADDRESS_I, wwd_pkg::IDX_TEST_B)) begin
            rdata_d[wwd_pkg::BYTE_W-1:0] = test_b_q;
        end else if (hit(AVS_ADDRESS_I, wwd_pkg::IDX_STATUS)) begin
            rdata_d[wwd_pkg::STA_ARMED]   = (arm_q == wwd_pkg::ARM_HALF);
            rdata_d[wwd_pkg::STA_ENABLED] = enabled;
            rdata_d[wwd_pkg::STA_ONCE]    = once_q;
            rdata_d[wwd_pkg::STA_FORCED]  = forced;
        end else if (hit(AVS_ADDRESS_I, wwd_pkg::IDX_CLKCFG)) begin
            rdata_d[wwd_pkg::CFG_SECONDARY] = cfg_q.secondary;
            rdata_d[wwd_pkg::CFG_PRIMARY]   = cfg_q.primary;
            rdata_d[wwd_pkg::CFG_PSTOP]     = cfg_q.pseudo_stop;
            rdata_d[wwd_pkg::CFG_PCE]       = cfg_q.pseudo_stop_clock_enable;
        end
    end

    // ------------------------------------------------------------------
    // control register: write-once, mask, sticky debug stop, nonvolatile load
    logic        mask, fields_ok, dbg_rise, restart_ctl, restart_load;
    logic [2:0]  wr_rate;

    always_comb begin
        ctrl_d       = ctrl_q;
        once_d       = once_q;
        restart_ctl  = 1'b0;
        restart_load = 1'b0;
        mask         = wd[wwd_pkg::CTL_MASK];
        wr_rate      = wd[wwd_pkg::CTL_RATE_LSB +: wwd_pkg::RATE_W];
        fields_ok    = !mask && (SPECIAL_MODE_I || !once_q);
        dbg_rise     = 1'b0;
        if (NVM_LOAD_I) begin
            // load wins over a bus write in the same cycle; it is taken whenever NVM_LOAD_I is high
            ctrl_d       = NVM_CTRL_I;
            restart_load = (NVM_CTRL_I.rate != wwd_pkg::RATE_OFF);
        end else if (wr_ctl) begin
            if (SPECIAL_MODE_I) begin
                ctrl_d.dbg_stop = wd[wwd_pkg::CTL_DBGSTOP];
            end else if (wd[wwd_pkg::CTL_DBGSTOP]) begin
                ctrl_d.dbg_stop = 1'b1;
            end
            dbg_rise = !ctrl_q.dbg_stop && wd[wwd_pkg::CTL_DBGSTOP];
            if (fields_ok) begin
                // zero values are no-ops but still spend the chance
                if (wr_rate != wwd_pkg::RATE_OFF) begin
                    ctrl_d.rate = wr_rate;
                end
                if (wd[wwd_pkg::CTL_WINDOW]) begin
                    ctrl_d.window = 1'b1;
                end
            end
            if (!mask && !SPECIAL_MODE_I) begin
                once_d = 1'b1;
            end
            if (SPECIAL_MODE_I) begin
                restart_ctl = 1'b1;
            end else begin
                restart_ctl = dbg_rise || (fields_ok &&
                              ((wr_rate != wwd_pkg::RATE_OFF) || wd[wwd_pkg::CTL_WINDOW]));
            end
        end
    end

    // ------------------------------------------------------------------
    // clock configuration and restarts from clock changes
    logic restart_clk, osc_lost;

    always_comb begin
        cfg_d       = cfg_q;
        restart_clk = 1'b0;
        if (wr_cfg) begin
            cfg_d.secondary   = wd[wwd_pkg::CFG_SECONDARY];
            cfg_d.primary     = wd[wwd_pkg::CFG_PRIMARY];
            cfg_d.pseudo_stop = wd[wwd_pkg::CFG_PSTOP];
            cfg_d.pseudo_stop_clock_enable         = wd[wwd_pkg::CFG_PCE];
            restart_clk = (cfg_d.secondary != cfg_q.secondary) ||
                          (cfg_d.primary != cfg_q.primary);
        end
        osc_lost = ovalid_prev_q && !ovalid_s && !cfg_q.primary && cfg_q.secondary;
        test_a_d = wr_test_a ? wd : test_a_q;
        test_b_d = wr_test_b ? wd : test_b_q;
    end

    // ------------------------------------------------------------------
    // counter, window check and service sequence
    logic [4:0]  exp_sel;
    logic [24:0] period, last, open_at;
    logic        win_eff, early, run, freeze, count_en;
    logic        wr_svc, svc_bad, svc_good, timeout, wd_fire, restart;

    always_comb begin
        enabled  = (ctrl_q.rate != wwd_pkg::RATE_OFF);
        forced   = enabled && DEBUG_ACTIVE_I && !ctrl_q.dbg_stop && SPECIAL_MODE_I;
        exp_sel  = forced ? wwd_pkg::EXP_FORCED : rate_exp(ctrl_q.rate, cfg_q.primary);
        win_eff  = ctrl_q.window && !forced;
        period   = CNT_ONE << exp_sel;
        last     = period - CNT_ONE;
        open_at  = period - (period >> 2);
        early    = (cnt_q < open_at);
        // stop-mode gating: primary branch never halts
        run      = !STOP_MODE_I || cfg_q.primary ||
                   (cfg_q.pseudo_stop && cfg_q.secondary && cfg_q.pseudo_stop_clock_enable);
        freeze   = ctrl_q.dbg_stop && DEBUG_ACTIVE_I;
        count_en = enabled && tick && run && !freeze;
        timeout  = count_en && (cnt_q == last);
        wr_svc   = wr_svc_raw && enabled;
        svc_bad  = wr_svc && (((wd != wwd_pkg::ARM_FIRST) && (wd != wwd_pkg::ARM_SECOND)) ||
                              (win_eff && early));
        svc_good = wr_svc && !svc_bad && (wd == wwd_pkg::ARM_SECOND) &&
                   (arm_q == wwd_pkg::ARM_HALF);
        wd_fire  = svc_bad || timeout;
        restart  = wd_fire || svc_good || restart_ctl || restart_clk || osc_lost || restart_load;
        if (restart) begin
            cnt_d = '0;
        end else if (count_en) begin
            cnt_d = cnt_q + CNT_ONE;
        end else begin
            cnt_d = cnt_q;
        end
        // a lone second byte is harmless; repeated first bytes just keep it armed
        if (restart) begin
            arm_d = wwd_pkg::ARM_IDLE;
        end else if (wr_svc && !svc_bad && (wd == wwd_pkg::ARM_FIRST)) begin
            arm_d = wwd_pkg::ARM_HALF;
        end else begin
            arm_d = arm_q;
        end
    end

    // ------------------------------------------------------------------
    // state registers; all outputs leave straight from here
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            wait_q            <= 1'b1;
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O    <= '0;
            ctrl_q            <= wwd_pkg::CTRL_RST;
            cfg_q             <= wwd_pkg::CLKCFG_RST;
            once_q            <= 1'b0;
            test_a_q          <= '0;
            test_b_q          <= '0;
            ovalid_prev_q     <= 1'b0;
            cnt_q             <= '0;
            arm_q             <= wwd_pkg::ARM_IDLE;
            WDOG_RESET_O      <= 1'b0;
            RTI_FREEZE_O      <= 1'b0;
        end else begin
            wait_q            <= wait_d;
            AVS_WAITREQUEST_O <= wait_d;
            AVS_READDATA_O    <= (req && wait_q) ? rdata_d : AVS_READDATA_O;
            ctrl_q            <= ctrl_d;
            cfg_q             <= cfg_d;
            once_q            <= once_d;
            test_a_q          <= test_a_d;
            test_b_q          <= test_b_d;
            ovalid_prev_q     <= ovalid_s;
            cnt_q             <= cnt_d;
            arm_q             <= arm_d;
            WDOG_RESET_O      <= wd_fire;
            RTI_FREEZE_O      <= freeze;
        end
    end

endmodule : wwd_top

// ===== testbench/wwd_chk_sva.sv
`timescale 1ns/1ps
// port-level checker for the watchdog block
module wwd_chk (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    input  wire logic [7:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    input  wire logic [31:0] AVS_READDATA_O,
    input  wire logic        AVS_WAITREQUEST_O,
    input  wire logic        DEBUG_ACTIVE_I,
    input  wire logic        NVM_LOAD_I,
    input  wire logic        WDOG_RESET_O,
    input  wire logic        RTI_FREEZE_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    logic       en_q;
    logic       en_d;
    logic       req;
    logic       done;
    logic [7:0] ctl_a;
    logic [7:0] svc_a;
    // bus decode shared by the properties
    assign req   = AVS_READ_I | AVS_WRITE_I;
    assign done  = req & ~AVS_WAITREQUEST_O;
    assign ctl_a = wwd_pkg::IDX_CONTROL << wwd_pkg::IDX_SHIFT;
    assign svc_a = wwd_pkg::IDX_SERVICE << wwd_pkg::IDX_SHIFT;
    // enabled is learnt from a control read; rate can only return to 000 by reload or reset
    always_comb begin
        en_d = en_q;
        if (NVM_LOAD_I) begin
            en_d = 1'b0;
        end else if (done && AVS_READ_I && AVS_ADDRESS_I == ctl_a) begin
            en_d = (AVS_READDATA_O[2:0] != 3'h0);
        end
    end
    always_ff @(posedge REF_CLK_I) begin
        en_q <= RST_I ? 1'b0 : en_d;
    end
    wait_answer_a: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("waitrequest not low one cycle after request");
    wait_pulse_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low for more than one cycle");
    idle_wait_a: assert property (!req && AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("answer without request");
    read_upper_a: assert property (done && AVS_READ_I |-> AVS_READDATA_O[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    svc_read_a: assert property (done && AVS_READ_I && AVS_ADDRESS_I == svc_a |-> AVS_READDATA_O == 32'h0000_0000)
        else $error("service register read not zero");
    ctl_read_a: assert property (done && AVS_READ_I && AVS_ADDRESS_I == ctl_a |-> AVS_READDATA_O[5:3] == 3'h0)
        else $error("mask bit reads back nonzero");
    pulse_one_a: assert property (WDOG_RESET_O |=> !WDOG_RESET_O)
        else $error("watchdog reset longer than one cycle");
    bad_service_a: assert property (en_q && done && AVS_WRITE_I && AVS_ADDRESS_I == svc_a && AVS_BYTEENABLE_I[0]
        && AVS_WRITEDATA_I[7:0] != 8'h55 && AVS_WRITEDATA_I[7:0] != 8'hAA |=> WDOG_RESET_O)
        else $error("bad service byte gave no reset");
    freeze_off_a: assert property (!DEBUG_ACTIVE_I ##1 !DEBUG_ACTIVE_I |-> !RTI_FREEZE_O)
        else $error("freeze without debug mode");
endmodule : wwd_chk
bind wwd_top wwd_chk wwd_chk_inst (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .DEBUG_ACTIVE_I(DEBUG_ACTIVE_I), .NVM_LOAD_I(NVM_LOAD_I), .WDOG_RESET_O(WDOG_RESET_O), .RTI_FREEZE_O(RTI_FREEZE_O));

// ===== testbench/wwd_host_model.sv
`timescale 1ns/1ps
// processor side: one bus master, request held until waitrequest is sampled low
module wwd_host_model (
    input  wire logic        clk_i,
    input  wire logic        wait_i,
    input  wire logic [31:0] rdata_i,
    output logic      [7:0]  addr_o,
    output logic             read_o,
    output logic             write_o,
    output logic      [31:0] wdata_o,
    output logic      [3:0]  be_o
);
    initial begin
        addr_o  = 8'h00;
        read_o  = 1'b0;
        write_o = 1'b0;
        wdata_o = 32'h0000_0000;
        be_o    = 4'h0;
    end
    // bounded wait so a silent slave cannot hang the run; service bytes come only from the caller
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q  = 32'h0000_0000;
        @(posedge clk_i);
        addr_o  <= a;
        read_o  <= !wr;
        write_o <= wr;
        wdata_o <= d;
        be_o    <= 4'h1;
        for (n = 0; n < 64 && !ok; n++) begin
            @(posedge clk_i);
            if (wait_i === 1'b0) begin
                ok = 1'b1;
                q  = rdata_i;
            end
        end
        read_o  <= 1'b0;
        write_o <= 1'b0;
    endtask : xfer
endmodule : wwd_host_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst = 1'b1, dbg = 1'b0, aclk = 1'b0, iclk = 1'b0, oclk = 1'b0, wr_o, rd_o, wq, frz, wdr;
    logic [7:0] ad;
    logic [31:0] wd, rdq, q;
    logic [3:0] be;
    logic ok;
    logic spc = 1'b0, stp = 1'b0, nvl = 1'b0;
    wwd_pkg::wwd_ctrl_s nvc = wwd_pkg::CTRL_RST;
    int err_count = 0, n_compared = 0, rst_seen = 0, seed = 76, n;
    logic [7:0] v;
    // fast source clocks keep the shortest period near two thousand cycles
    always #4 clk = ~clk;
    always #32 aclk = ~aclk;
    always #41 iclk = ~iclk;
    always #53 oclk = ~oclk;
    always @(posedge clk) if (wdr === 1'b1) rst_seen++;
    wwd_host_model wwd_host_model_inst (.clk_i(clk), .wait_i(wq), .rdata_i(rdq), .addr_o(ad), .read_o(rd_o),
        .write_o(wr_o), .wdata_o(wd), .be_o(be));
    wwd_top wwd_top_inst (.REF_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(ad), .AVS_READ_I(rd_o), .AVS_WRITE_I(wr_o),
        .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdq), .AVS_WAITREQUEST_O(wq),
        .SPECIAL_MODE_I(spc), .STOP_MODE_I(stp), .DEBUG_ACTIVE_I(dbg), .NVM_LOAD_I(nvl),
        .NVM_CTRL_I(nvc), .AUTO_CLK_I(aclk), .IRC_CLK_I(iclk), .OSC_CLK_I(oclk),
        .OSC_VALID_I(1'b1), .WDOG_RESET_O(wdr), .RTI_FREEZE_O(frz));
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // register access by index; a lost answer counts as a mismatch
    task automatic acc(input logic [7:0] idx, input logic w, input logic [31:0] d);
        wwd_host_model_inst.xfer(idx << wwd_pkg::IDX_SHIFT, w, d, q, ok);
        cmp("bus answer", 32'h0000_0001, {31'h0, ok});
    endtask : acc
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        acc(wwd_pkg::IDX_CONTROL, 1'b0, 0); cmp("control reset", 32'h0000_0000, q);
        acc(wwd_pkg::IDX_SERVICE, 1'b0, 0); cmp("service read", 32'h0000_0000, q);
        acc(8'h20 | ($random(seed) & 8'h0F), 1'b0, 0); cmp("unmapped read", 32'h0000_0000, q);
        acc(wwd_pkg::IDX_SERVICE, 1'b1, 32'h0000_0012);
        repeat (8) @(posedge clk);
        cmp("ignored service", 32'h0000_0000, rst_seen);
        acc(wwd_pkg::IDX_CLKCFG, 1'b1, 32'h0000_0002);
        acc(wwd_pkg::IDX_CONTROL, 1'b1, 32'h0000_0001);
        acc(wwd_pkg::IDX_STATUS, 1'b0, 0); cmp("status enabled", 32'h0000_0006, q);
        acc(wwd_pkg::IDX_CONTROL, 1'b1, 32'h0000_0087);
        acc(wwd_pkg::IDX_CONTROL, 1'b0, 0); cmp("write once", 32'h0000_0001, q);
        acc(wwd_pkg::IDX_CONTROL, 1'b1, 32'h0000_00E7);
        acc(wwd_pkg::IDX_CONTROL, 1'b0, 0); cmp("masked write", 32'h0000_0041, q);
        acc(wwd_pkg::IDX_CONTROL, 1'b1, 32'h0000_0000);
        acc(wwd_pkg::IDX_CONTROL, 1'b0, 0); cmp("debug stop kept", 32'h0000_0041, q);
        dbg <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("freeze in debug", 32'h0000_0001, {31'h0, frz});
        dbg <= 1'b0;
        acc(wwd_pkg::IDX_SERVICE, 1'b1, 32'h0000_0055);
        acc(wwd_pkg::IDX_STATUS, 1'b0, 0); cmp("armed", 32'h0000_0007, q);
        acc(wwd_pkg::IDX_SERVICE, 1'b1, 32'h0000_0055);
        acc(wwd_pkg::IDX_SERVICE, 1'b1, 32'h0000_00AA);
        acc(wwd_pkg::IDX_STATUS, 1'b0, 0); cmp("pair clears arm", 32'h0000_0006, q);
        cmp("no reset on pair", 32'h0000_0000, rst_seen);
        v = 8'h55;
        while (v == 8'h55 || v == 8'hAA) v = $random(seed);
        acc(wwd_pkg::IDX_SERVICE, 1'b1, {24'h00_0000, v});
        repeat (2) @(posedge clk);
        cmp("bad byte reset", 32'h0000_0001, rst_seen);
        // unserviced: 2^7 ticks, each two autonomous edges of eight cycles
        for (n = 0; n < 4000 && rst_seen < 2; n++) @(posedge clk);
        cmp("timeout near 2048", 32'h0000_0001, {31'h0, n >= 2030 && n <= 2070});
        // nonvolatile load sets window mode; a service write right away falls in the closed part
        nvc <= '{window: 1'b1, dbg_stop: 1'b1, rate: 3'h1};
        nvl <= 1'b1;
        @(posedge clk);
        nvl <= 1'b0;
        acc(wwd_pkg::IDX_CONTROL, 1'b0, 0); cmp("nvm load", 32'h0000_00C1, q);
        acc(wwd_pkg::IDX_SERVICE, 1'b1, 32'h0000_0055);
        repeat (2) @(posedge clk);
        cmp("early service", 32'h0000_0003, rst_seen);
        // stop mode must not halt the primary branch, else the pair below would land early
        stp <= 1'b1;
        repeat (1700) @(posedge clk);
        acc(wwd_pkg::IDX_SERVICE, 1'b1, 32'h0000_0055);
        acc(wwd_pkg::IDX_SERVICE, 1'b1, 32'h0000_0055);
        acc(wwd_pkg::IDX_SERVICE, 1'b1, 32'h0000_00AA);
        stp <= 1'b0;
        repeat (2) @(posedge clk);
        cmp("late service", 32'h0000_0003, rst_seen);
        // special mode: debug-stop may be cleared, and debugging then forces the longest period
        spc <= 1'b1;
        acc(wwd_pkg::IDX_CONTROL, 1'b1, 32'h0000_0000);
        acc(wwd_pkg::IDX_CONTROL, 1'b0, 0); cmp("special clear", 32'h0000_0081, q);
        dbg <= 1'b1;
        acc(wwd_pkg::IDX_STATUS, 1'b0, 0); cmp("forced period", 32'h0000_000E, q);
        dbg <= 1'b0;
        spc <= 1'b0;
        complete_run();
    end
endmodule : tb
